/* File: cdb_wavegen.sv */
// complementary waveform generator with rising and falling dead-band counts
// assumes avalon-mm master on sys_clk_i; all inputs synchronous to sys_clk_i
// Summary of operation
// RULE1: rising count bits 5-0; nonzero n delays primary output n to n+1 counts.
// RULE2: falling count bits 5-0; nonzero n delays complementary output n to n+1 counts.
// RULE3: a zero count bypasses the dead band and passes that edge straight through.
// RULE4: bits 7-6 of both count registers read zero and ignore writes.
// RULE5: count fields are read/write, set only at power-on, kept over soft reset.
// RULE6: delay counts on the selected generator clock; primary after rise, complement after fall.
module cdb_wavegen
  import cdb_pkg::*;
#(
  parameter int unsigned NUM_SRC = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic soft_rst_i,
  input wire logic [CDB_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [NUM_SRC-1:0] wave_src_i,
  input wire logic alt_clk_tick_i,
  input wire logic fault_n_i,
  input wire logic comp_one_i,
  input wire logic comp_two_i,
  output logic out_a_o,
  output logic out_b_o,
  output logic out_a_en_o,
  output logic out_b_en_o
);
  logic [7:0] wavegen_control_zero;
  logic [7:0] wavegen_control_one;
  logic [7:0] wavegen_control_two;
  logic [7:0] falling_dead_band_count;
  logic [7:0] rising_dead_band_count;
  logic ack_q;
  logic wr_acc;
  logic [7:0] next_rdata;
  logic generator_enable;
  logic generator_clock_select;
  logic [1:0] input_waveform_select;
  logic auto_shutdown_event_flag;
  logic auto_restart_enable;
  logic shutdown_req;
  logic gen_tick;
  logic wave_in;
  logic wave_q;
  logic prim_raw;
  logic comp_raw;
  logic [1:0] sd_state_a;
  logic [1:0] sd_state_b;

  assign generator_enable = wavegen_control_zero[CDB_C0_GEN_EN];
  assign generator_clock_select = wavegen_control_zero[CDB_C0_CLK_SEL];
  assign input_waveform_select = wavegen_control_one[CDB_C1_IS_LO +: 2];
  assign sd_state_a = wavegen_control_one[CDB_C1_SDA_LO +: 2];
  assign sd_state_b = wavegen_control_one[CDB_C1_SDB_LO +: 2];
  assign auto_shutdown_event_flag = wavegen_control_two[CDB_C2_ASE];
  assign auto_restart_enable = wavegen_control_two[CDB_C2_ARSEN];

  // one wait cycle per access: ack_q marks the edge at which it completes
  // a frozen clock holds the answer back, else a write would finish without landing
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~(ack_q & clk_en_i);
  assign wr_acc = avs_write_i & ack_q & avs_byteenable_i[0];

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else if (clk_en_i) begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (avs_address_i)
      CDB_ADDR_CTRL0: next_rdata = wavegen_control_zero;
      CDB_ADDR_CTRL1: next_rdata = wavegen_control_one;
      CDB_ADDR_CTRL2: next_rdata = wavegen_control_two;
      CDB_ADDR_DBF: next_rdata = falling_dead_band_count & CDB_DB_MASK; // [RULE4]
      CDB_ADDR_DBR: next_rdata = rising_dead_band_count & CDB_DB_MASK; // [RULE4]
      default: next_rdata = 8'h00;
    endcase
  end

  // unmapped reads return zero, unmapped writes are dropped
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (clk_en_i && avs_read_i && !ack_q) begin
      avs_readdata_o <= {24'h00_0000, next_rdata};
    end
  end

  // control registers follow both resets
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wavegen_control_zero <= CDB_RESET_VAL;
      wavegen_control_one <= CDB_RESET_VAL;
    end else if (clk_en_i) begin
      if (soft_rst_i) begin
        wavegen_control_zero <= CDB_RESET_VAL;
        wavegen_control_one <= CDB_RESET_VAL;
      end else if (wr_acc && avs_address_i == CDB_ADDR_CTRL0) begin
        wavegen_control_zero <= avs_writedata_i[7:0] & CDB_C0_MASK;
      end else if (wr_acc && avs_address_i == CDB_ADDR_CTRL1) begin
        wavegen_control_one <= avs_writedata_i[7:0] & CDB_C1_MASK;
      end
    end
  end

  // counts are only set by power-on reset; soft reset leaves them alone
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rising_dead_band_count <= CDB_RESET_VAL;
      falling_dead_band_count <= CDB_RESET_VAL;
    end else if (clk_en_i && wr_acc) begin // [RULE5]
      if (avs_address_i == CDB_ADDR_DBR) begin
        rising_dead_band_count <= avs_writedata_i[7:0] & CDB_DB_MASK; // [RULE1] [RULE4]
      end
      if (avs_address_i == CDB_ADDR_DBF) begin
        falling_dead_band_count <= avs_writedata_i[7:0] & CDB_DB_MASK; // [RULE2] [RULE4]
      end
    end
  end

  // shutdown sources; fault pin is active low
  assign shutdown_req = (wavegen_control_two[CDB_C2_SRC_FLT] & ~fault_n_i)
                      | (wavegen_control_two[CDB_C2_SRC_C1] & comp_one_i)
                      | (wavegen_control_two[CDB_C2_SRC_C2] & comp_two_i);

  // event flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wavegen_control_two <= CDB_RESET_VAL;
    end else if (clk_en_i) begin
      if (soft_rst_i) begin
        wavegen_control_two <= CDB_RESET_VAL;
      end else begin
        if (wr_acc && avs_address_i == CDB_ADDR_CTRL2) begin
          wavegen_control_two <= avs_writedata_i[7:0] & CDB_C2_MASK;
        end else if (auto_restart_enable && !shutdown_req && wave_in && !wave_q) begin
          wavegen_control_two[CDB_C2_ASE] <= 1'b0;
        end
        if (shutdown_req && generator_enable) begin
          wavegen_control_two[CDB_C2_ASE] <= 1'b1;
        end
      end
    end
  end

  // clock select 0 counts every system clock, 1 counts the alternate tick
  assign gen_tick = generator_clock_select ? alt_clk_tick_i : 1'b1; // [RULE6]
  assign wave_in = generator_enable & wave_src_i[input_waveform_select];

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wave_q <= 1'b0;
    end else if (clk_en_i) begin
      wave_q <= wave_in;
    end
  end

  // primary delayed after the input rises, complement after it falls
  cdb_edge_delay #(.CNT_W(CDB_CNT_W)) u_rise_delay ( // [RULE6]
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(clk_en_i),
    .tick_i(gen_tick),
    .in_i(wave_q),
    .count_i(rising_dead_band_count[CDB_CNT_W-1:0]),
    .out_o(prim_raw)
  );

  cdb_edge_delay #(.CNT_W(CDB_CNT_W)) u_fall_delay (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(clk_en_i),
    .tick_i(gen_tick),
    .in_i(generator_enable & ~wave_q),
    .count_i(falling_dead_band_count[CDB_CNT_W-1:0]),
    .out_o(comp_raw)
  );

  // outputs registered; shutdown overrides with the selected drive state
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_a_o <= 1'b0;
      out_b_o <= 1'b0;
      out_a_en_o <= 1'b0;
      out_b_en_o <= 1'b0;
    end else if (clk_en_i) begin
      out_a_en_o <= generator_enable & wavegen_control_zero[CDB_C0_OE_A];
      out_b_en_o <= generator_enable & wavegen_control_zero[CDB_C0_OE_B];
      if (auto_shutdown_event_flag) begin
        out_a_o <= (sd_state_a == CDB_SD_HIGH) ? 1'b1 :
                   (sd_state_a == CDB_SD_LOW) ? 1'b0 : wavegen_control_zero[CDB_C0_POL_A];
        out_b_o <= (sd_state_b == CDB_SD_HIGH) ? 1'b1 :
                   (sd_state_b == CDB_SD_LOW) ? 1'b0 : wavegen_control_zero[CDB_C0_POL_B];
      end else begin
        out_a_o <= prim_raw ^ wavegen_control_zero[CDB_C0_POL_A];
        out_b_o <= comp_raw ^ wavegen_control_zero[CDB_C0_POL_B];
      end
    end
  end

  sequence s_dbr_write;
    clk_en_i && wr_acc && avs_address_i == CDB_ADDR_DBR;
  endsequence

  sequence s_dbf_write;
    clk_en_i && wr_acc && avs_address_i == CDB_ADDR_DBF;
  endsequence

  AST_DBR_STORE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE1]
    s_dbr_write |=> (rising_dead_band_count == {2'b00, $past(avs_writedata_i[5:0])}))
    else $error("rising count not stored from the write");
  AST_DBF_STORE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE2]
    s_dbf_write |=> (falling_dead_band_count == {2'b00, $past(avs_writedata_i[5:0])}))
    else $error("falling count not stored from the write");
  AST_UPPER_ZERO: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE4]
    (clk_en_i && avs_read_i && !ack_q && (avs_address_i == CDB_ADDR_DBR || avs_address_i == CDB_ADDR_DBF))
    |=> (avs_readdata_o[7:6] == 2'b00)) else $error("unimplemented count bits read nonzero");
  AST_SOFT_KEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE5]
    (soft_rst_i && !wr_acc) |=> ($stable(rising_dead_band_count) && $stable(falling_dead_band_count)))
    else $error("soft reset disturbed a dead-band count");
  AST_BYPASS_TIMING: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE3]
    (clk_en_i && rising_dead_band_count == 8'h00 && !auto_shutdown_event_flag && $rose(wave_q)
     && !wavegen_control_zero[CDB_C0_POL_A] && $stable(wavegen_control_zero) && generator_enable)
    |=> (out_a_o || !clk_en_i)) else $error("zero rising count still delayed the primary output");
  AST_ACK_ONE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && (avs_read_i || avs_write_i) && !ack_q) |=> (!avs_waitrequest_o || !clk_en_i))
    else $error("bus access not answered after one wait cycle");
endmodule : cdb_wavegen

/* File: cdb_pkg.sv */
// constants for the complementary waveform generator with dead-band timing
// assumes a 32-bit avalon-mm slave with one register per aligned word
package cdb_pkg;
  localparam int unsigned CDB_ADDR_W = 5;
  localparam int unsigned CDB_CNT_W = 6;
  // register byte addresses
  localparam logic [4:0] CDB_ADDR_CTRL0 = 5'h00;
  localparam logic [4:0] CDB_ADDR_CTRL1 = 5'h04;
  localparam logic [4:0] CDB_ADDR_CTRL2 = 5'h08;
  localparam logic [4:0] CDB_ADDR_DBF = 5'h0c;
  localparam logic [4:0] CDB_ADDR_DBR = 5'h10;
  // wavegen_control_zero fields
  localparam int unsigned CDB_C0_GEN_EN = 7;
  localparam int unsigned CDB_C0_OE_B = 6;
  localparam int unsigned CDB_C0_OE_A = 5;
  localparam int unsigned CDB_C0_POL_B = 4;
  localparam int unsigned CDB_C0_POL_A = 3;
  localparam int unsigned CDB_C0_CLK_SEL = 0;
  localparam logic [7:0] CDB_C0_MASK = 8'hf9;
  // wavegen_control_one fields
  localparam int unsigned CDB_C1_SDB_LO = 6;
  localparam int unsigned CDB_C1_SDA_LO = 4;
  localparam int unsigned CDB_C1_IS_LO = 0;
  localparam logic [7:0] CDB_C1_MASK = 8'hf3;
  // wavegen_control_two fields
  localparam int unsigned CDB_C2_ASE = 7;
  localparam int unsigned CDB_C2_ARSEN = 6;
  localparam int unsigned CDB_C2_SRC_C2 = 3;
  localparam int unsigned CDB_C2_SRC_C1 = 2;
  localparam int unsigned CDB_C2_SRC_FLT = 1;
  localparam logic [7:0] CDB_C2_MASK = 8'hce;
  // dead-band count registers: bits 7-6 unimplemented
  localparam logic [7:0] CDB_DB_MASK = 8'h3f;
  localparam logic [7:0] CDB_RESET_VAL = 8'h00;
  // shutdown drive states
  localparam logic [1:0] CDB_SD_LOW = 2'b10;
  localparam logic [1:0] CDB_SD_HIGH = 2'b11;
endpackage : cdb_pkg

/* File: cdb_edge_delay.sv */
// one dead-band delay stage: delays the rise of its input, passes the fall at once
// assumes tick_i marks counts of the selected generator clock, synchronous to clk_i
module cdb_edge_delay
  import cdb_pkg::*;
#(
  parameter int unsigned CNT_W = CDB_CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic in_i,
  input wire logic [CNT_W-1:0] count_i,
  output logic out_o
);
  logic [CNT_W-1:0] cnt;
  logic dly_q;
  logic bypass;

  assign bypass = (count_i == '0);
  // zero count passes the input straight through
  assign out_o = in_i & (bypass | dly_q); // [RULE3]

  // ticks are not aligned to the input edge, hence n to n+1 counts
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '0;
      dly_q <= 1'b0;
    end else if (ce_i) begin
      if (!in_i) begin
        cnt <= '0;
        dly_q <= 1'b0;
      end else if (!dly_q && tick_i) begin // [RULE6]
        if (cnt + 1'b1 >= count_i) begin // [RULE1] [RULE2]
          dly_q <= 1'b1;
        end
        cnt <= cnt + 1'b1;
      end
    end
  end

  sequence s_input_fall;
    ce_i && $fell(in_i);
  endsequence

  AST_BYPASS_PASS: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    bypass |-> (out_o == in_i)) else $error("zero count does not pass the input through");
  AST_FALL_DROPS: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    s_input_fall |-> !out_o) else $error("output did not drop with the input");
  AST_NO_EARLY_RISE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    ($rose(out_o) && !bypass) |-> ($past(cnt) + 7'h01 >= {1'b0, count_i}))
    else $error("output rose before the dead band ran out");
  AST_TICK_ONLY: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
    (ce_i && !tick_i && in_i && $past(in_i)) |=> $stable(cnt))
    else $error("dead-band count advanced without a generator clock tick");
endmodule : cdb_edge_delay

/* File: cdb_wavegen_tb.sv */
// self-checking bench for cdb_wavegen: register access and dead-band timing
// assumes both generator clock selects in turn, polarity 0, no shutdown source
module cdb_wavegen_tb;
  import cdb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic soft_rst_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [3:0] wave_src_i = 4'h0;
  logic alt_clk_tick_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic out_a_o;
  logic out_b_o;
  logic out_a_en_o;
  logic out_b_en_o;
  logic mon_on = 1'b0;
  logic src_q = 1'b0;
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  logic ce_rand = 1'b0;
  logic en_probe = 1'b0;
  logic use_alt = 1'b0;
  logic [31:0] exp_rd[$];
  int exp_da[$];
  int exp_db[$];
  logic [1:0] exp_en[$];
  int cyc = 0;
  int t_rise = 0;
  int t_fall = 0;
  int rk = 0;
  int rk_p = 0;
  int fk = 0;
  int fk_p = 0;
  int num_errors = 0;
  int checks = 0;

  cdb_wavegen u_dut (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clk_en_i(clk_en_i),
    .soft_rst_i(soft_rst_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .wave_src_i(wave_src_i),
    .alt_clk_tick_i(alt_clk_tick_i),
    .fault_n_i(1'b1),
    .comp_one_i(1'b0),
    .comp_two_i(1'b0),
    .out_a_o(out_a_o),
    .out_b_o(out_b_o),
    .out_a_en_o(out_a_en_o),
    .out_b_en_o(out_b_en_o)
  );

  always #10 sys_clk_i = ~sys_clk_i;

  // tick only matters with clock select 1, but keeps that input live
  always @(posedge sys_clk_i) begin
    alt_clk_tick_i <= 1'($urandom_range(1));
    clk_en_i <= ce_rand ? 1'($urandom_range(1)) : 1'b1;
  end

  task automatic final_report();
    num_errors += exp_rd.size() + exp_da.size() + exp_db.size() + exp_en.size();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t exp=%0h got=%0h", $time, e, g);
    end
  endtask : cmp_rd

  task automatic cmp_dly(input int e, input int g);
    checks++;
    if (g != e) begin
      num_errors++;
      $display("BAD t=%0t exp=%0h got=%0h", $time, e, g);
    end
  endtask : cmp_dly

  task automatic cmp_en(input logic [1:0] e, input logic [1:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t exp=%0h got=%0h", $time, e, g);
    end
  endtask : cmp_en

  // monitor sees pre-edge values: all design outputs are registered or follow registers
  always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (cyc > 5000) begin
      num_errors++;
      final_report();
    end
    if (avs_read_i && avs_waitrequest_o === 1'b0)
      cmp_rd(exp_rd.size() ? exp_rd.pop_front() : 32'hdead_beef, avs_readdata_o);
    if (en_probe)
      cmp_en(exp_en.size() ? exp_en.pop_front() : 2'bxx, {out_a_en_o, out_b_en_o});
    if (wave_src_i[0] && !src_q) t_rise = cyc;
    if (!wave_src_i[0] && src_q) t_fall = cyc;
    // alternate tick: wait checked in ticks, counted up to the edge that ended it
    if (mon_on && out_a_o === 1'b1 && a_q === 1'b0)
      cmp_dly(exp_da.size() ? exp_da.pop_front() : -1, use_alt ? rk_p : cyc - t_rise);
    if (mon_on && out_b_o === 1'b1 && b_q === 1'b0)
      cmp_dly(exp_db.size() ? exp_db.pop_front() : -1, use_alt ? fk_p : cyc - t_fall);
    rk_p = rk;
    fk_p = fk;
    rk = (wave_src_i[0] && !src_q) ? 0 : rk + int'(!use_alt || alt_clk_tick_i);
    fk = (!wave_src_i[0] && src_q) ? 0 : fk + int'(!use_alt || alt_clk_tick_i);
    src_q = wave_src_i[0];
    a_q = out_a_o;
    b_q = out_b_o;
  end

  task automatic bus_write(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= 1'b1;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : bus_write

  task automatic bus_read(input logic [4:0] a, input logic [7:0] e);
    exp_rd.push_back({24'h0, e});
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : bus_read

  // one full source period; the hold outlasts the longest dead band in either clock mode
  task automatic run_case(input logic [5:0] nr, input logic [5:0] nf, input logic alt);
    bus_write(CDB_ADDR_CTRL0, {24'h0, 7'h70, alt}, 4'h1);
    bus_write(CDB_ADDR_DBR, {26'h0, nr}, 4'h1);
    bus_write(CDB_ADDR_DBF, {26'h0, nf}, 4'h1);
    use_alt <= alt;
    exp_da.push_back(alt ? int'(nr) : int'(nr) + 2);
    wave_src_i <= {3'($urandom_range(7)), 1'b1};
    repeat (alt ? 200 : 70) @(posedge sys_clk_i);
    exp_db.push_back(alt ? int'(nf) : int'(nf) + 2);
    wave_src_i <= {3'($urandom_range(7)), 1'b0};
    repeat (alt ? 200 : 70) @(posedge sys_clk_i);
  endtask : run_case

  initial begin
    logic [5:0] tr [10];
    logic [5:0] tf [10];
    logic [31:0] rv;
    void'($urandom(32'h9de78ad2));
    tr = '{6'h00, 6'h01, 6'h3f, 6'h02, 6'h00, 6'h00, 6'h00, 6'h3f, 6'h00, 6'h05};
    tf = '{6'h00, 6'h3f, 6'h01, 6'h00, 6'h02, 6'h00, 6'h00, 6'h01, 6'h3f, 6'h00};
    rv = $urandom();
    for (int i = 4; i < 7; i++) begin
      tr[i] = 6'($urandom_range(63));
      tf[i] = 6'($urandom_range(63));
    end
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    bus_read(CDB_ADDR_DBR, 8'h00);
    bus_read(CDB_ADDR_DBF, 8'h00);
    // clock enable dropped at random: the bus must stretch, not lose the access
    ce_rand <= 1'b1;
    bus_write(CDB_ADDR_DBR, rv, 4'hf);
    bus_read(CDB_ADDR_DBR, {2'b00, rv[5:0]});
    ce_rand <= 1'b0;
    bus_write(CDB_ADDR_DBR, 32'hffff_ffc5, 4'hf);
    bus_read(CDB_ADDR_DBR, 8'h05);
    bus_write(CDB_ADDR_DBF, 32'h0000_00ea, 4'hf);
    bus_read(CDB_ADDR_DBF, 8'h2a);
    // byte lane 0 off: write must vanish
    bus_write(CDB_ADDR_DBF, 32'h0000_0011, 4'he);
    bus_read(CDB_ADDR_DBF, 8'h2a);
    bus_read(5'h14, 8'h00);
    bus_write(CDB_ADDR_CTRL0, 32'h0000_00e0, 4'h1);
    bus_read(CDB_ADDR_CTRL0, 8'he0);
    exp_en.push_back(2'b11);
    en_probe <= 1'b1;
    soft_rst_i <= 1'b1;
    @(posedge sys_clk_i);
    en_probe <= 1'b0;
    soft_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    exp_en.push_back(2'b00);
    en_probe <= 1'b1;
    @(posedge sys_clk_i);
    en_probe <= 1'b0;
    bus_read(CDB_ADDR_CTRL0, 8'h00);
    bus_read(CDB_ADDR_DBR, 8'h05);
    bus_read(CDB_ADDR_DBF, 8'h2a);
    bus_write(CDB_ADDR_CTRL0, 32'h0000_00e0, 4'h1);
    // let the complement settle high before timing edges
    repeat (80) @(posedge sys_clk_i);
    mon_on <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      run_case(tr[i], tf[i], i > 6);
    end
    final_report();
  end
endmodule : cdb_wavegen_tb
